// ### fba_pkg.sv
// constants, register map and carriers for the buffer admission block
// assumes one system clock and a single AHB-Lite master
package fba_pkg;
    localparam int CW = 8;
    localparam int NPORT = 6;
    localparam int NCLS = 3;
    localparam int DW = 32;
    localparam int DRW = 16;
    // register byte offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_PRES = 8'h04;
    localparam logic [7:0] A_CRES = 8'h08;
    localparam logic [7:0] A_THR = 8'h0c;
    localparam logic [7:0] A_STAT = 8'h10;
    localparam logic [7:0] A_DROPS = 8'h14;
    // field positions
    localparam int CTRL_PAUSE_LSB = 0;
    localparam int CTRL_PCT_LSB = 8;
    localparam int PRES_FAST_LSB = 0;
    localparam int PRES_HOST_LSB = 8;
    localparam int PRES_UPL_LSB = 16;
    localparam int CRES_SHR_LSB = 0;
    localparam int CRES_CLS_LSB = 8;
    localparam int THR_XOFF_LSB = 0;
    localparam int THR_LOW_LSB = 8;
    localparam int THR_MC_LSB = 16;
    localparam int THR_TMP_LSB = 24;
    localparam int ST_XOFF_LSB = 0;
    localparam int ST_MC_LSB = 8;
    localparam int ST_TMP_LSB = 16;
    localparam int ST_SHR_LSB = 24;
    // reset values
    localparam logic [DW-1:0] CTRL_RST = 32'h0000_1900;
    localparam logic [DW-1:0] PRES_RST = 32'h0010_0808;
    localparam logic [DW-1:0] CRES_RST = 32'h0808_0820;
    localparam logic [DW-1:0] THR_RST = 32'h1010_0404;
    // misc
    localparam logic [CW-1:0] PCT_MOD = 8'h64;
    localparam logic [CW-1:0] XOFF_MIN = 8'h02;
    localparam logic [2:0] PRIO_MIN_RES = 3'h2;
    localparam logic [2:0] PORT_UPLINK = 3'h4;
    localparam logic [2:0] PORT_HOST = 3'h5;
    localparam int HTRANS_ACT = 1;

    typedef enum logic [1:0] {RG_NONE, RG_CLASS, RG_SHARED, RG_PORT} fba_region_e;

    typedef struct packed {
        logic [2:0] port;
        logic [2:0] prio;
        logic be;
        logic unicast_congest_level;
        logic mcast;
    } fba_rsp_s;

    typedef struct packed {
        fba_region_e region;
        logic [2:0] port;
        logic [2:0] prio;
        logic mcast;
    } fba_rel_s;

    typedef struct packed {
        logic valid;
        logic drop;
        fba_region_e region;
    } fba_dec_s;
endpackage

// ### fba_admit.sv
// frame data buffer admission, drop decision and pause control
// assumes the frame engine on the same clock and an AHB-Lite master
//
// Behaviour
// - new frames sit in the temporary region until the switch response arrives
// - three class reserves: priorities 2-3, 4-5 and 6-7, each programmable
// - priorities 0 and 1 never get a class reservation
// - class regions are counted per priority pair, not per transmit queue
// - six source-port reserves: four fast ports, uplink, host port
// - allocate class first, then shared pool, then source-port reserve
// - best-effort frame dropped when the shared pool and its source-port reserve both lack buffer
// - congested queue and empty shared pool drop a programmed percentage
// - congested queue and port reserve below low threshold drop the frame
// - pause-capable source ports skip the percentage and low-threshold drops, but are dropped when no region has room
// - pause-capable ports raise a pause request on buffer shortage
// - unicast pause asserted once programmed count of port slots used
// - pause released once every slot of that port is freed
// - a single frame never pauses its source port
// - multicast pause asserted when multicast count exceeds threshold
// - multicast pause released when count falls below threshold
// - priority classification ignores the outgoing port pause setting
// - traffic from pause-capable ports handled as best effort
// - drops come only from buffer scarcity or queue congestion
//
// The AHB-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ns
module fba_admit (
    input wire logic SYS_CLK,
    input wire logic SRST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic RX_REQ,
    output logic RX_READY,
    input wire logic RSP_VALID,
    input wire fba_pkg::fba_rsp_s RSP,
    input wire logic REL_VALID,
    input wire fba_pkg::fba_rel_s REL,
    output fba_pkg::fba_dec_s DEC,
    output logic [5:0] XOFF,
    output logic MC_XOFF
);
    import fba_pkg::*;

    typedef struct packed {
        logic [DW-1:0] ctrl;
        logic [DW-1:0] pres;
        logic [DW-1:0] cres;
        logic [DW-1:0] thr;
        logic [NCLS-1:0][CW-1:0] cls;
        logic [NPORT-1:0][CW-1:0] prt;
        logic [CW-1:0] shr;
        logic [CW-1:0] tmp;
        logic [CW-1:0] mc;
        logic [CW-1:0] rnd;
        logic [NPORT-1:0] xoff;
        logic mcx;
        fba_dec_s dec;
        logic [DRW-1:0] drops;
        logic wr;
        logic [7:0] waddr;
        logic [DW-1:0] rdata;
    } fba_state_s;

    fba_state_s r_q;
    fba_state_s r_d;

    function automatic logic [1:0] cls_idx(input logic [2:0] prio);
        logic [1:0] hi;
        hi = prio[2:1];
        return hi - 2'h1;
    endfunction

    function automatic logic [CW-1:0] cnt_upd(input logic [CW-1:0] c,
                                              input logic inc, input logic dec);
        logic [CW-1:0] v;
        v = c;
        if (inc && !dec) begin
            v = c + 8'h01;
        end else if (dec && !inc) begin
            v = c - 8'h01;
        end
        return v;
    endfunction

    function automatic logic [CW-1:0] port_res(input logic [2:0] p,
                                               input logic [DW-1:0] pres);
        logic [CW-1:0] v;
        v = pres[PRES_FAST_LSB +: CW];
        if (p == PORT_UPLINK) begin
            v = pres[PRES_UPL_LSB +: CW];
        end else if (p == PORT_HOST) begin
            v = pres[PRES_HOST_LSB +: CW];
        end
        return v;
    endfunction

    function automatic logic cls_room(input logic [1:0] ci,
                                      input logic [NCLS-1:0][CW-1:0] cnt,
                                      input logic [DW-1:0] cres);
        logic ok;
        ok = 1'b0;
        for (int i = 0; i < NCLS; i++) begin
            if (ci == 2'(i)) begin
                ok = cnt[i] < cres[CRES_CLS_LSB + CW * i +: CW];
            end
        end
        return ok;
    endfunction

    logic ahb_acc;
    logic rx_in;
    logic pe;
    logic be;
    logic [2:0] eprio;
    logic [1:0] ci;
    logic [CW-1:0] pres;
    logic [CW-1:0] pfree;
    logic [CW-1:0] thr_eff;
    logic [CW-1:0] mc_thr;
    logic cls_ok;
    logic shr_ok;
    logic prt_ok;
    fba_region_e region;
    logic drp7;
    logic drp8;
    logic drp9;
    logic drop;
    logic alloc;
    logic [DW-1:0] stat;

    always_comb begin
        r_d = r_q;
        // bus slave: capture address phase, write in data phase
        ahb_acc = HSEL && HTRANS[HTRANS_ACT] && HREADY;
        r_d.wr = ahb_acc && HWRITE;
        r_d.waddr = HADDR[7:0];
        stat = '0;
        stat[ST_XOFF_LSB +: NPORT] = r_q.xoff;
        stat[ST_MC_LSB] = r_q.mcx;
        stat[ST_TMP_LSB +: CW] = r_q.tmp;
        stat[ST_SHR_LSB +: CW] = r_q.shr;
        if (ahb_acc && !HWRITE) begin
            case (HADDR[7:0])
                A_CTRL: r_d.rdata = r_q.ctrl;
                A_PRES: r_d.rdata = r_q.pres;
                A_CRES: r_d.rdata = r_q.cres;
                A_THR: r_d.rdata = r_q.thr;
                A_STAT: r_d.rdata = stat;
                A_DROPS: r_d.rdata = {{(DW-DRW){1'b0}}, r_q.drops};
                default: r_d.rdata = '0;
            endcase
        end
        if (r_q.wr) begin
            case (r_q.waddr)
                A_CTRL: r_d.ctrl = HWDATA;
                A_PRES: r_d.pres = HWDATA;
                A_CRES: r_d.cres = HWDATA;
                A_THR: r_d.thr = HWDATA;
                default: r_d.ctrl = r_q.ctrl;
            endcase
        end

        // temporary region holds frames awaiting the switch response
        rx_in = RX_REQ && RX_READY;
        r_d.tmp = cnt_upd(r_q.tmp, rx_in, RSP_VALID);

        // classification of the response
        pe = r_q.ctrl[CTRL_PAUSE_LSB + int'(RSP.port)];
        be = RSP.be || pe;
        eprio = pe ? 3'h0 : RSP.prio;
        ci = cls_idx(eprio);
        cls_ok = (eprio >= PRIO_MIN_RES) && cls_room(ci, r_q.cls, r_q.cres);
        shr_ok = r_q.shr < r_q.cres[CRES_SHR_LSB +: CW];
        pres = port_res(RSP.port, r_q.pres);
        prt_ok = r_q.prt[RSP.port] < pres;
        pfree = prt_ok ? (pres - r_q.prt[RSP.port]) : '0;
        if (cls_ok) begin
            region = RG_CLASS;
        end else if (shr_ok) begin
            region = RG_SHARED;
        end else if (prt_ok) begin
            region = RG_PORT;
        end else begin
            region = RG_NONE;
        end
        // scarcity drops for best-effort frames only
        drp7 = be && !shr_ok && !prt_ok;
        drp8 = be && RSP.unicast_congest_level && !shr_ok
            && (r_q.rnd < r_q.ctrl[CTRL_PCT_LSB +: CW]);
        drp9 = be && RSP.unicast_congest_level && (pfree < r_q.thr[THR_LOW_LSB +: CW]);
        drop = ((drp7 || drp8 || drp9) && !pe) || (region == RG_NONE);
        alloc = RSP_VALID && !drop;
        r_d.dec.valid = RSP_VALID;
        r_d.dec.drop = RSP_VALID && drop;
        r_d.dec.region = alloc ? region : RG_NONE;
        if (RSP_VALID && drop) begin
            r_d.drops = r_q.drops + 16'h0001;
        end
        r_d.rnd = (r_q.rnd >= PCT_MOD - 8'h01) ? '0 : r_q.rnd + 8'h01;

        // occupancy counters
        for (int i = 0; i < NCLS; i++) begin
            r_d.cls[i] = cnt_upd(r_q.cls[i],
                alloc && region == RG_CLASS && ci == 2'(i),
                REL_VALID && REL.region == RG_CLASS && cls_idx(REL.prio) == 2'(i));
        end
        for (int i = 0; i < NPORT; i++) begin
            r_d.prt[i] = cnt_upd(r_q.prt[i],
                alloc && region == RG_PORT && RSP.port == 3'(i),
                REL_VALID && REL.region == RG_PORT && REL.port == 3'(i));
        end
        r_d.shr = cnt_upd(r_q.shr, alloc && region == RG_SHARED,
            REL_VALID && REL.region == RG_SHARED);
        r_d.mc = cnt_upd(r_q.mc, alloc && RSP.mcast, REL_VALID && REL.mcast);

        // unicast pause per source port
        thr_eff = r_q.thr[THR_XOFF_LSB +: CW];
        if (thr_eff < XOFF_MIN) begin
            thr_eff = XOFF_MIN;
        end
        for (int i = 0; i < NPORT; i++) begin
            if (!r_q.ctrl[CTRL_PAUSE_LSB + i]) begin
                r_d.xoff[i] = 1'b0;
            end else if (r_q.prt[i] >= thr_eff) begin
                r_d.xoff[i] = 1'b1;
            end else if (r_q.xoff[i] && r_q.prt[i] == '0) begin
                r_d.xoff[i] = 1'b0;
            end
        end

        // multicast pause
        mc_thr = r_q.thr[THR_MC_LSB +: CW];
        if (r_q.mc > mc_thr) begin
            r_d.mcx = 1'b1;
        end else if (r_q.mc < mc_thr) begin
            r_d.mcx = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            r_q <= '0;
            r_q.ctrl <= CTRL_RST;
            r_q.pres <= PRES_RST;
            r_q.cres <= CRES_RST;
            r_q.thr <= THR_RST;
        end else begin
            r_q <= r_d;
        end
    end

    assign HRDATA = r_q.rdata;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign RX_READY = r_q.tmp < r_q.thr[THR_TMP_LSB +: CW];
    assign DEC = r_q.dec;
    assign XOFF = r_q.xoff;
    assign MC_XOFF = r_q.mcx;

    // checks
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (SRST);

    AST_TMP_IN: assert property (RX_REQ && RX_READY && !RSP_VALID
        |=> r_q.tmp == CW'($past(r_q.tmp) + 8'h01))
        else $error("temp count did not rise on accepted frame");
    AST_CLS_FIRST: assert property (RSP_VALID && cls_ok && !drop
        |=> DEC.valid && DEC.region == RG_CLASS)
        else $error("class reserve not used first");
    AST_LOW_NOCLS: assert property (RSP_VALID && eprio < PRIO_MIN_RES
        |=> DEC.region != RG_CLASS)
        else $error("low priority took a class slot");
    AST_PAUSE_KEEP: assert property (RSP_VALID && pe && region != RG_NONE
        |=> DEC.valid && !DEC.drop)
        else $error("pause-capable port frame dropped");
    AST_LOWTHR_DROP: assert property (RSP_VALID && drp9 && !pe
        |=> DEC.valid && DEC.drop ##1 (!DEC.valid || $past(RSP_VALID)))
        else $error("low threshold drop missing");
    AST_XOFF_SET: assert property (r_q.ctrl[CTRL_PAUSE_LSB] && r_q.prt[0] >= thr_eff
        |=> XOFF[0])
        else $error("xoff not raised on port 0");
    AST_XON: assert property (XOFF[0] && r_q.prt[0] == '0 |=> !XOFF[0])
        else $error("xon not given after release");
    AST_SINGLE: assert property ($rose(XOFF[0]) |-> $past(r_q.prt[0]) >= XOFF_MIN)
        else $error("port paused by a single frame");
    AST_MC_OFF: assert property (r_q.mc > mc_thr |=> MC_XOFF)
        else $error("multicast xoff missing");
    AST_MC_ON: assert property (r_q.mc < mc_thr |=> !MC_XOFF)
        else $error("multicast xon missing");
    AST_SHR_CNT: assert property (alloc && region == RG_SHARED
        && !(REL_VALID && REL.region == RG_SHARED)
        |=> r_q.shr == CW'($past(r_q.shr) + 8'h01))
        else $error("shared count not advanced");

    // temporary region and decision pulse
    AST_TMP_OUT: assert property (RSP_VALID && !(RX_REQ && RX_READY)
        |=> r_q.tmp == CW'($past(r_q.tmp) - 8'h01))
        else $error("temp count did not fall on response");
    AST_TMP_FULL: assert property (RX_REQ && !RX_READY && !RSP_VALID
        |=> $stable(r_q.tmp))
        else $error("temp count moved while temp region full");
    AST_DEC_VALID: assert property (RSP_VALID |=> DEC.valid)
        else $error("decision missing after response");
    AST_DEC_IDLE: assert property (!RSP_VALID |=> !DEC.valid && !DEC.drop)
        else $error("decision without response");

    // region choice and reserves
    AST_CLS_CNT: assert property (alloc && region == RG_CLASS
        && !(REL_VALID && REL.region == RG_CLASS)
        |=> r_q.cls[$past(ci)] == CW'($past(r_q.cls[ci]) + 8'h01))
        else $error("class pair count not advanced");
    AST_FAST_RES: assert property (RSP_VALID && RSP.port < PORT_UPLINK
        && r_q.prt[RSP.port] >= r_q.pres[PRES_FAST_LSB +: CW]
        |=> DEC.region != RG_PORT)
        else $error("fast port reserve overrun");
    AST_UPL_RES: assert property (RSP_VALID && RSP.port == PORT_UPLINK
        && r_q.prt[PORT_UPLINK] >= r_q.pres[PRES_UPL_LSB +: CW]
        |=> DEC.region != RG_PORT)
        else $error("uplink reserve overrun");
    AST_HOST_RES: assert property (RSP_VALID && RSP.port == PORT_HOST
        && r_q.prt[PORT_HOST] >= r_q.pres[PRES_HOST_LSB +: CW]
        |=> DEC.region != RG_PORT)
        else $error("host port reserve overrun");

    // drop decisions
    AST_BE_DROP: assert property (RSP_VALID && be && !pe && !shr_ok && !prt_ok
        |=> DEC.valid && DEC.drop)
        else $error("best-effort frame kept without port room");
    AST_PCT_ALL: assert property (RSP_VALID && be && !pe && RSP.unicast_congest_level && !shr_ok
        && r_q.ctrl[CTRL_PCT_LSB +: CW] >= PCT_MOD
        |=> DEC.drop)
        else $error("full percentage did not drop");
    AST_NO_BW_DROP: assert property (RSP_VALID && !be && region != RG_NONE
        |=> !DEC.drop)
        else $error("non best-effort frame dropped with room");
    AST_PAUSE_BE: assert property (RSP_VALID && pe |=> DEC.region != RG_CLASS)
        else $error("pause-capable port frame took a class slot");

    // pause requests
    AST_PAUSE_OFF: assert property (!r_q.ctrl[CTRL_PAUSE_LSB] |=> !XOFF[0])
        else $error("pause raised with pause disabled");
    AST_XOFF_HOLD: assert property (XOFF[0] && r_q.ctrl[CTRL_PAUSE_LSB]
        && r_q.prt[0] != '0 |=> XOFF[0])
        else $error("pause released with slots still held");
    AST_MC_HOLD: assert property (r_q.mc == mc_thr |=> MC_XOFF == $past(MC_XOFF))
        else $error("multicast pause moved at threshold");

    // occupancy counters
    AST_PORT_CNT: assert property (alloc && region == RG_PORT && RSP.port == 3'h0
        && !(REL_VALID && REL.region == RG_PORT && REL.port == 3'h0)
        |=> r_q.prt[0] == CW'($past(r_q.prt[0]) + 8'h01))
        else $error("port 0 count not advanced");
    AST_SHR_REL: assert property (REL_VALID && REL.region == RG_SHARED
        && !(alloc && region == RG_SHARED)
        |=> r_q.shr == CW'($past(r_q.shr) - 8'h01))
        else $error("shared count not released");
    AST_MC_CNT: assert property (alloc && RSP.mcast && !(REL_VALID && REL.mcast)
        |=> r_q.mc == CW'($past(r_q.mc) + 8'h01))
        else $error("multicast count not advanced");

    COV_DROP: cover property (RSP_VALID && drop && !pe);
    COV_PAUSE: cover property (XOFF[0] ##[1:200] !XOFF[0]);
    COV_MC: cover property ($rose(MC_XOFF));
    COV_PORT: cover property (alloc && region == RG_PORT);
    COV_PCT: cover property (RSP_VALID && drp8 && !pe);
endmodule

// ### fba_engine.sv
// frame engine and queue manager model on the far side of the admission block
// assumes one caller that enters each task right after a rising clock edge
`timescale 1ns/1ns
module fba_engine (
    input wire logic clk,
    input wire fba_pkg::fba_dec_s dec,
    output fba_pkg::fba_rsp_s rsp,
    output fba_pkg::fba_rel_s rel,
    output logic rx_req,
    output logic rsp_valid,
    output logic rel_valid
);
    import fba_pkg::*;
    initial begin
        rx_req = 1'b0;
        rsp_valid = 1'b0;
        rel_valid = 1'b0;
        rsp = '0;
        rel = '0;
    end
    // new frame asks for a temporary slot
    task automatic rx();
        rx_req <= 1'b1;
        @(posedge clk);
        rx_req <= 1'b0;
        @(posedge clk);
    endtask
    // switch response, hands back the decision
    task automatic respond(input fba_rsp_s r, output fba_dec_s d);
        rsp_valid <= 1'b1;
        rsp <= r;
        @(posedge clk);
        rsp_valid <= 1'b0;
        rsp <= ~r;
        #1 d = dec;
        @(posedge clk);
    endtask
    // frame freed by the queue manager
    task automatic freed(input fba_rel_s r);
        rel_valid <= 1'b1;
        rel <= r;
        @(posedge clk);
        rel_valid <= 1'b0;
        rel <= ~r;
        @(posedge clk);
    endtask
endmodule

// ### test_fba_admit.sv
// self-checking bench for the buffer admission block
// assumes fba_pkg and the frame engine model are compiled first
`timescale 1ns/1ns
module test_fba_admit;
    import fba_pkg::*;
    typedef struct packed {
        logic [2:0] port;
        logic [2:0] prio;
        logic be;
        logic unicast_congest_level;
        logic mcast;
        fba_region_e region;
        logic drop;
    } fba_row_s;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = '0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, rx_req, rx_ready, rsp_valid, rel_valid, mc_xoff;
    logic [5:0] xoff;
    fba_rsp_s rsp;
    fba_rel_s rel;
    fba_dec_s dec;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    fba_row_s rows [5] = '{'{3'h0, 3'h2, 1'b0, 1'b0, 1'b0, RG_CLASS, 1'b0},
        '{3'h3, 3'h7, 1'b1, 1'b1, 1'b0, RG_CLASS, 1'b0},
        '{3'h4, 3'h0, 1'b0, 1'b0, 1'b0, RG_SHARED, 1'b0},
        '{3'h5, 3'h1, 1'b0, 1'b0, 1'b1, RG_SHARED, 1'b0},
        '{3'h1, 3'h4, 1'b0, 1'b0, 1'b0, RG_CLASS, 1'b0}};
    logic [31:0] rv [4] = '{CTRL_RST, PRES_RST, CRES_RST, THR_RST};
    logic [31:0] sc_ctrl [4] = '{32'h0000_6400, 32'h0, 32'h0, 32'h0000_0001};
    logic [31:0] sc_thr [4] = '{THR_RST, 32'h1010_0904, 32'h1010_0904, 32'h1010_0904};
    logic [3:0] sc_ucc = 4'b1011;
    logic [3:0] sc_drop = 4'b0011;
    int cap [3] = '{1, 3, 2};
    fba_admit i_fba_admit (.SYS_CLK(clk), .SRST(srst), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .RX_REQ(rx_req),
        .RX_READY(rx_ready), .RSP_VALID(rsp_valid), .RSP(rsp), .REL_VALID(rel_valid),
        .REL(rel), .DEC(dec), .XOFF(xoff), .MC_XOFF(mc_xoff));
    fba_engine i_fba_engine (.clk(clk), .dec(dec), .rsp(rsp), .rel(rel), .rx_req(rx_req),
        .rsp_valid(rsp_valid), .rel_valid(rel_valid));
    initial begin
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic rst();
        srst <= 1'b1;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= wr;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
        hsel <= 1'b0;
        @(posedge clk);
    endtask
    task automatic admit(input fba_row_s r);
        fba_dec_s d;
        i_fba_engine.rx();
        i_fba_engine.respond('{r.port, r.prio, r.be, r.unicast_congest_level, r.mcast}, d);
        chk({30'h0, d.valid, d.drop}, {30'h0, 1'b1, r.drop}, "decision");
        if (!r.drop)
            chk({30'h0, d.region}, {30'h0, r.region}, "region");
    endtask
    task automatic free(input fba_region_e g, input logic [2:0] p, input logic m);
        i_fba_engine.freed('{g, p, 3'h0, m});
    endtask
    initial begin
        fba_dec_s d;
        rst();
        for (int i = 0; i < 4; i++) begin
            ahb(1'b0, 8'(4 * i), '0);
            chk(rd, rv[i], "reset value");
        end
        ahb(1'b0, 8'h18, '0);
        chk(rd, '0, "unmapped read");
        ahb(1'b1, A_DROPS, 32'hffff_ffff);
        ahb(1'b0, A_DROPS, '0);
        chk(rd, '0, "drops read only");
        foreach (rows[i]) begin
            admit(rows[i]);
            i_fba_engine.freed('{rows[i].region, rows[i].port, rows[i].prio, rows[i].mcast});
        end
        $display("test rows done");
        rst();
        ahb(1'b1, A_CRES, 32'h0101_0101);
        for (int i = 0; i < 11; i++) begin
            admit('{3'h0, 3'h2, 1'b0, 1'b0, 1'b0,
                i == 0 ? RG_CLASS : i == 1 ? RG_SHARED : RG_PORT, i == 10});
        end
        ahb(1'b0, A_STAT, '0);
        chk(rd & 32'hffff_0000, 32'h0100_0000, "shared and temp counts");
        ahb(1'b0, A_DROPS, '0);
        chk(rd, 32'h1, "drop count");
        $display("test allocation order done");
        rst();
        ahb(1'b1, A_CRES, 32'h0808_0800);
        for (int i = 0; i < 4; i++) begin
            ahb(1'b1, A_CTRL, sc_ctrl[i]);
            ahb(1'b1, A_THR, sc_thr[i]);
            admit('{3'h0, 3'h0, 1'b1, sc_ucc[i], 1'b0, RG_PORT, sc_drop[i]});
        end
        $display("test scarcity drops done");
        rst();
        ahb(1'b1, A_CTRL, 32'h0000_1901);
        ahb(1'b1, A_CRES, 32'h0808_0800);
        for (int i = 0; i < 4; i++) begin
            admit('{3'h0, 3'h7, 1'b0, 1'b0, 1'b0, RG_PORT, 1'b0});
            repeat (3) @(posedge clk);
            chk(32'(xoff), (i == 3) ? 32'h1 : 32'h0, "pause level");
        end
        for (int i = 0; i < 4; i++) begin
            free(RG_PORT, 3'h0, 1'b0);
            repeat (3) @(posedge clk);
            chk(32'(xoff), (i == 3) ? 32'h0 : 32'h1, "resume level");
        end
        $display("test unicast pause done");
        rst();
        ahb(1'b1, A_THR, 32'h1001_0404);
        for (int i = 0; i < 4; i++) begin
            if (i < 2)
                admit('{3'h2, 3'h0, 1'b0, 1'b0, 1'b1, RG_SHARED, 1'b0});
            else
                free(RG_SHARED, 3'h2, 1'b1);
            repeat (3) @(posedge clk);
            chk(32'(mc_xoff), {31'h0, i == 1 || i == 2}, "multicast pause");
        end
        $display("test multicast pause done");
        rst();
        ahb(1'b1, A_PRES, 32'h0003_0201);
        ahb(1'b1, A_CRES, 32'h0);
        for (int i = 0; i < 12; i++) begin
            admit('{3'(3 + i / 4), 3'h2, 1'b1, 1'b0, 1'b0, RG_PORT,
                i % 4 >= cap[i / 4]});
        end
        $display("test port reserves done");
        rst();
        ahb(1'b1, A_THR, 32'h0210_0404);
        for (int i = 0; i < 3; i++) begin
            chk(32'(rx_ready), {31'h0, i < 2}, "temp room");
            i_fba_engine.rx();
        end
        ahb(1'b0, A_STAT, '0);
        chk(rd & 32'h00ff_0000, 32'h0002_0000, "temp count");
        i_fba_engine.respond('{3'h0, 3'h0, 1'b0, 1'b0, 1'b0}, d);
        chk(32'(rx_ready), 32'h1, "temp freed");
        $display("test temporary region done");
        stop_test();
    end
endmodule
